// File: design/flash_seq_defs.svh
`ifndef FLASH_SEQ_DEFS_SVH
`define FLASH_SEQ_DEFS_SVH

// word address layout: block number sits in the upper bits
`define ADDR_W            24
`define BLK_LSB           16
`define BUF_WORDS         32
`define BUF_IDX_W         5
`define BUF_LAST_IDX      5'h1f

// command codes on the low data byte
`define CMD_BUFFERED_FACTORY_PROGRAM          8'h80
`define CMD_READ_ARRAY    8'hff
`define CMD_QUERY         8'h98
`define CMD_CLR_STATUS    8'h50
`define EXIT_DATA         16'hffff

// status register field positions and reset value
`define SR_READY          7
`define SR_VPP_ERR        3
`define SR_LOCK_ERR       1
`define SR_BUSY           0
`define STATUS_RESET      8'h80

// query database offsets (word addresses) and contents
`define QRY_SIG_FIRST_OFF     8'h10
`define QRY_SIG_SECOND_OFF    8'h11
`define QRY_SIG_THIRD_OFF     8'h12
`define QRY_PRI_ID_LOW_OFF    8'h13
`define QRY_PRI_ID_HIGH_OFF   8'h14
`define QRY_EXT_PTR_LOW_OFF   8'h15
`define QRY_EXT_PTR_HIGH_OFF  8'h16
`define QRY_ALT_ID_LOW_OFF    8'h17
`define QRY_ALT_ID_HIGH_OFF   8'h18
`define QRY_ALT_PTR_LOW_OFF   8'h19
`define QRY_ALT_PTR_HIGH_OFF  8'h1a
`define QRY_SIG_FIRST         8'h51
`define QRY_SIG_SECOND        8'h52
`define QRY_SIG_THIRD         8'h59
`define QRY_EXT_PTR           16'h010a
`define QRY_ALT_ID            16'h0000
`define QRY_ALT_PTR           16'h0000

// timing, in ns, and the clock period they are divided by
`define MCLK_PERIOD_NS    25
`define SETUP_NS          100
`define WORD_PROG_NS      200
`define EXIT_NS           100

`endif

// File: design/flash_seq_pkg.sv
package flash_seq_pkg;

    typedef enum logic [7:0] {
        S_ARRAY  = 8'h01,
        S_QUERY  = 8'h02,
        S_STATUS = 8'h04,
        S_SETUP  = 8'h08,
        S_CHECK  = 8'h10,
        S_LOAD   = 8'h20,
        S_PROG   = 8'h40,
        S_EXIT   = 8'h80
    } seq_state_t;

endpackage

// File: design/write_buffer.sv
`timescale 1ns/1ps
`include "flash_seq_defs.svh"

module write_buffer (
    input  wire logic                    mclk,
    input  wire logic                    wrEn,
    input  wire logic [`BUF_IDX_W-1:0]   wrIdx,
    input  wire logic [15:0]             wrData,
    input  wire logic [`BUF_IDX_W-1:0]   rdIdx,
    output logic      [15:0]             rdData
);

    logic [15:0] word_reg [`BUF_WORDS];

    genvar i;
    generate
        for (i = 0; i < `BUF_WORDS; i++) begin : g_word
            always_ff @(posedge mclk) begin
                if (wrEn && wrIdx == `BUF_IDX_W'(i)) begin
                    word_reg[i] <= wrData;
                end
            end
        end
    endgenerate

    assign rdData = word_reg[rdIdx];

endmodule // write_buffer

// File: design/query_rom.sv
`timescale 1ns/1ps
`include "flash_seq_defs.svh"

module query_rom #(
    // arbitrary value
    parameter logic [15:0] PRI_CMDSET_ID = 16'h0007
) (
    input  wire logic [7:0] offset,
    output logic      [7:0] qByte
);

    function automatic logic [7:0] lookup(input logic [7:0] off);
        logic [7:0] b;
        b = 8'h00;
        case (off)
            `QRY_SIG_FIRST_OFF:    b = `QRY_SIG_FIRST;
            `QRY_SIG_SECOND_OFF:   b = `QRY_SIG_SECOND;
            `QRY_SIG_THIRD_OFF:    b = `QRY_SIG_THIRD;
            `QRY_PRI_ID_LOW_OFF:   b = PRI_CMDSET_ID[7:0];
            `QRY_PRI_ID_HIGH_OFF:  b = PRI_CMDSET_ID[15:8];
            `QRY_EXT_PTR_LOW_OFF:  b = 8'(`QRY_EXT_PTR);
            `QRY_EXT_PTR_HIGH_OFF: b = 8'(`QRY_EXT_PTR >> 8);
            `QRY_ALT_ID_LOW_OFF:   b = 8'(`QRY_ALT_ID);
            `QRY_ALT_ID_HIGH_OFF:  b = 8'(`QRY_ALT_ID >> 8);
            `QRY_ALT_PTR_LOW_OFF:  b = 8'(`QRY_ALT_PTR);
            `QRY_ALT_PTR_HIGH_OFF: b = 8'(`QRY_ALT_PTR >> 8);
            default:               b = 8'h00;
        endcase
        return b;
    endfunction

    // low byte first at the lower offset
    assign qByte = lookup(offset);

endmodule // query_rom

// File: design/flash_buffered_program_and_query.sv
`timescale 1ns/1ps
`include "flash_seq_defs.svh"

module flash_buffered_program_and_query (
    input  wire logic                 mclk,
    input  wire logic                 reset,
    input  wire logic [`ADDR_W-1:0]   addrIn,
    input  wire logic [15:0]          dqIn,
    output logic      [15:0]          dqOut,
    output logic                      dqDriveN,
    input  wire logic                 chipEnN,
    input  wire logic                 writeEnN,
    input  wire logic                 outEnN,
    input  wire logic                 highProgramVoltage,
    input  wire logic                 blockLocked,
    input  wire logic [15:0]          arrayRdData,
    output logic                      arrayWe,
    output logic      [`ADDR_W-1:0]   arrayAddr,
    output logic      [15:0]          arrayData
);

    localparam int SETUP_I = (`SETUP_NS + `MCLK_PERIOD_NS - 1)
                             / `MCLK_PERIOD_NS;
    localparam int PROG_I  = (`WORD_PROG_NS + `MCLK_PERIOD_NS - 1)
                             / `MCLK_PERIOD_NS;
    localparam int EXIT_I  = (`EXIT_NS + `MCLK_PERIOD_NS - 1)
                             / `MCLK_PERIOD_NS;
    localparam logic [7:0] SETUP_CYC = 8'(SETUP_I);
    localparam logic [7:0] PROG_CYC  = 8'(PROG_I);
    localparam logic [7:0] EXIT_CYC  = 8'(EXIT_I);

    flash_seq_pkg::seq_state_t state_reg;
    flash_seq_pkg::seq_state_t state_next;

    logic                    wePrev_reg;
    logic [`ADDR_W-1:0]      startAddr_reg;
    logic [`ADDR_W-1:0]      progAddr_reg;
    logic [`BUF_IDX_W-1:0]   loadIdx_reg;
    logic [`BUF_IDX_W-1:0]   progIdx_reg;
    logic [7:0]              timer_reg;
    logic                    errVpp_reg;
    logic                    errLock_reg;
    logic [15:0]             dqOut_reg;
    logic                    dqDriveN_reg;
    logic                    arrayWe_reg;
    logic [`ADDR_W-1:0]      arrayAddr_reg;
    logic [15:0]             arrayData_reg;
    logic [`ADDR_W-1:0]      prevArrAddr_reg;
    logic                    havePrev_reg;
    logic [9:0]              progCyc_reg;

    wire logic        wrStrobe;
    wire logic        rdActive;
    wire logic [7:0]  cmd;
    wire logic        inBlock;
    wire logic        atFirst;
    wire logic        idleState;
    wire logic        befpState;
    wire logic        timerDone;
    wire logic        loadWrite;
    wire logic        exitWrite;
    wire logic        progStep;
    wire logic        confirmWrite;
    wire logic        setupErr;
    wire logic        srReady;
    wire logic        srBusy;
    wire logic [7:0]  srView;
    wire logic [7:0]  qByte;
    wire logic [15:0] bufRd;
    logic      [15:0] rdData;

    // write taken on the rising edge of the write enable
    assign wrStrobe  = writeEnN && !wePrev_reg && !chipEnN;
    assign rdActive  = !chipEnN && !outEnN;
    assign cmd       = dqIn[7:0];
    assign inBlock   = addrIn[`ADDR_W-1:`BLK_LSB]
                       == startAddr_reg[`ADDR_W-1:`BLK_LSB];
    assign atFirst   = addrIn == startAddr_reg;
    assign idleState = state_reg == flash_seq_pkg::S_ARRAY
                    || state_reg == flash_seq_pkg::S_QUERY
                    || state_reg == flash_seq_pkg::S_STATUS;
    assign befpState = !idleState;
    assign timerDone = timer_reg == 8'h00;

    assign confirmWrite = wrStrobe && state_reg == flash_seq_pkg::S_SETUP
                          && cmd == `CMD_BUFFERED_FACTORY_PROGRAM && atFirst;
    assign setupErr     = !highProgramVoltage || blockLocked;
    // exit is a 0xffff write outside the current block
    assign exitWrite = wrStrobe && state_reg == flash_seq_pkg::S_LOAD
                       && dqIn == `EXIT_DATA && !inBlock;
    // data only taken while the busy bit is low
    assign loadWrite = wrStrobe && state_reg == flash_seq_pkg::S_LOAD
                       && !exitWrite;
    assign progStep  = state_reg == flash_seq_pkg::S_PROG && timerDone;

    assign srReady = idleState
                  || state_reg == flash_seq_pkg::S_CHECK;
    assign srBusy  = state_reg == flash_seq_pkg::S_PROG;
    assign srView  = {srReady, 3'b000, errVpp_reg, 1'b0, errLock_reg,
                      srBusy};

    // query offsets are word addresses on the x16 bus
    query_rom u_query (
        .offset (addrIn[7:0]),
        .qByte  (qByte)
    );

    write_buffer u_buf (
        .mclk   (mclk),
        .wrEn   (loadWrite),
        .wrIdx  (loadIdx_reg),
        .wrData (dqIn),
        .rdIdx  (progIdx_reg),
        .rdData (bufRd)
    );

    always_comb begin
        rdData = arrayRdData;
        case (state_reg)
            flash_seq_pkg::S_ARRAY:  rdData = arrayRdData;
            flash_seq_pkg::S_QUERY:  rdData = {8'h00, qByte};
            flash_seq_pkg::S_STATUS: rdData = {8'h00, srView};
            default: begin
                if (atFirst) begin
                    rdData = {8'h00, srView};
                end
            end
        endcase
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            flash_seq_pkg::S_ARRAY,
            flash_seq_pkg::S_QUERY,
            flash_seq_pkg::S_STATUS: begin
                if (wrStrobe) begin
                    case (cmd)
                        `CMD_READ_ARRAY: state_next = flash_seq_pkg::S_ARRAY;
                        `CMD_QUERY:      state_next = flash_seq_pkg::S_QUERY;
                        `CMD_BUFFERED_FACTORY_PROGRAM:       state_next = flash_seq_pkg::S_SETUP;
                        `CMD_CLR_STATUS: state_next = flash_seq_pkg::S_STATUS;
                        default:         state_next = state_reg;
                    endcase
                end
            end
            flash_seq_pkg::S_SETUP: begin
                if (confirmWrite) begin
                    state_next = flash_seq_pkg::S_CHECK;
                end else if (wrStrobe) begin
                    state_next = flash_seq_pkg::S_STATUS;
                end
            end
            flash_seq_pkg::S_CHECK: begin
                if (timerDone) begin
                    state_next = (errVpp_reg || errLock_reg)
                               ? flash_seq_pkg::S_STATUS
                               : flash_seq_pkg::S_LOAD;
                end
            end
            flash_seq_pkg::S_LOAD: begin
                if (exitWrite) begin
                    state_next = flash_seq_pkg::S_EXIT;
                end else if (loadWrite && loadIdx_reg == `BUF_LAST_IDX) begin
                    state_next = flash_seq_pkg::S_PROG;
                end
            end
            flash_seq_pkg::S_PROG: begin
                if (progStep && progIdx_reg == `BUF_LAST_IDX) begin
                    state_next = flash_seq_pkg::S_LOAD;
                end
            end
            flash_seq_pkg::S_EXIT: begin
                if (timerDone) begin
                    state_next = flash_seq_pkg::S_STATUS;
                end
            end
            default: state_next = flash_seq_pkg::S_ARRAY;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg  <= flash_seq_pkg::S_ARRAY;
            wePrev_reg <= 1'b1;
        end else begin
            state_reg  <= state_next;
            wePrev_reg <= writeEnN;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            startAddr_reg <= '0;
            loadIdx_reg   <= '0;
        end else if (idleState && wrStrobe && cmd == `CMD_BUFFERED_FACTORY_PROGRAM) begin
            startAddr_reg <= addrIn;
            loadIdx_reg   <= '0;
        end else if (loadWrite) begin
            loadIdx_reg   <= loadIdx_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            timer_reg <= 8'h00;
        end else if (confirmWrite) begin
            timer_reg <= SETUP_CYC - 8'h01;
        end else if (exitWrite) begin
            timer_reg <= EXIT_CYC - 8'h01;
        end else if (progStep || (state_next == flash_seq_pkg::S_PROG
                     && state_reg != flash_seq_pkg::S_PROG)) begin
            timer_reg <= PROG_CYC - 8'h01;
        end else if (!timerDone) begin
            timer_reg <= timer_reg - 8'h01;
        end
    end

    // errors held; cleared by clear status outside the sequence or reloaded at confirm, so no set collides
    always_ff @(posedge mclk) begin
        if (reset) begin
            errVpp_reg  <= 1'b0;
            errLock_reg <= 1'b0;
        end else if (confirmWrite) begin
            errVpp_reg  <= !highProgramVoltage;
            errLock_reg <= blockLocked;
        end else if (idleState && wrStrobe && cmd == `CMD_CLR_STATUS) begin
            errVpp_reg  <= 1'b0;
            errLock_reg <= 1'b0;
        end
    end

    // array programming walks the buffer from the first word upward
    always_ff @(posedge mclk) begin
        if (reset) begin
            progAddr_reg  <= '0;
            progIdx_reg   <= '0;
            arrayWe_reg   <= 1'b0;
            arrayAddr_reg <= '0;
            arrayData_reg <= 16'h0000;
        end else begin
            arrayWe_reg <= progStep;
            if (confirmWrite) begin
                progAddr_reg <= startAddr_reg;
                progIdx_reg  <= '0;
            end else if (progStep) begin
                arrayAddr_reg <= progAddr_reg;
                arrayData_reg <= bufRd;
                progAddr_reg  <= progAddr_reg + 1'b1;
                progIdx_reg   <= progIdx_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            dqOut_reg    <= 16'h0000;
            dqDriveN_reg <= 1'b1;
        end else begin
            dqOut_reg    <= rdData;
            dqDriveN_reg <= !rdActive;
        end
    end

    assign dqOut     = dqOut_reg;
    assign dqDriveN  = dqDriveN_reg;
    assign arrayWe   = arrayWe_reg;
    assign arrayAddr = arrayAddr_reg;
    assign arrayData = arrayData_reg;

    // helpers for the address order and programming time checks
    always_ff @(posedge mclk) begin
        progCyc_reg <= (srBusy && !reset) ? progCyc_reg + 10'h001 : 10'h000;
        if (reset || confirmWrite) begin
            havePrev_reg    <= 1'b0;
            prevArrAddr_reg <= '0;
        end else if (arrayWe_reg) begin
            havePrev_reg    <= 1'b1;
            prevArrAddr_reg <= arrayAddr_reg;
        end
    end

    a_setup_error: assert property (@(posedge mclk) disable iff (reset)
        state_reg == flash_seq_pkg::S_CHECK && timerDone && setupErr
        |=> state_reg == flash_seq_pkg::S_STATUS && srView[`SR_READY])
        else $error("setup error did not end with ready bit set");

    a_load_ready: assert property (@(posedge mclk) disable iff (reset)
        state_reg == flash_seq_pkg::S_LOAD |-> !srView[`SR_BUSY])
        else $error("busy bit high during data load");

    a_prog_busy: assert property (@(posedge mclk) disable iff (reset)
        $rose(state_reg == flash_seq_pkg::S_PROG)
        |-> srView[`SR_BUSY] [*8])
        else $error("busy bit dropped during programming");

    a_prog_ends: assert property (@(posedge mclk) disable iff (reset)
        srBusy |-> progCyc_reg < 10'(`BUF_WORDS * (PROG_I + 1)))
        else $error("buffer programming did not finish");

    a_word_order: assert property (@(posedge mclk) disable iff (reset)
        arrayWe_reg && havePrev_reg
        |-> arrayAddr_reg == prevArrAddr_reg + 1'b1)
        else $error("array address did not step by one");

    a_ignore_busy: assert property (@(posedge mclk) disable iff (reset)
        state_reg == flash_seq_pkg::S_PROG && wrStrobe
        |=> $stable(loadIdx_reg))
        else $error("data taken while busy");

    a_exit_ready: assert property (@(posedge mclk) disable iff (reset)
        exitWrite |=> !srView[`SR_READY] [*2]
        ##[0:8] state_reg == flash_seq_pkg::S_STATUS && srView[`SR_READY])
        else $error("exit ready bit sequence wrong");

    a_errors_kept: assert property (@(posedge mclk) disable iff (reset)
        state_reg == flash_seq_pkg::S_EXIT
        |=> errVpp_reg == $past(errVpp_reg)
            && errLock_reg == $past(errLock_reg))
        else $error("error bits lost across exit");

    a_read_array: assert property (@(posedge mclk) disable iff (reset)
        idleState && wrStrobe && cmd == `CMD_READ_ARRAY
        |=> state_reg == flash_seq_pkg::S_ARRAY)
        else $error("read array command not obeyed");

    a_query_sig: assert property (@(posedge mclk) disable iff (reset)
        state_reg == flash_seq_pkg::S_QUERY && rdActive
        && addrIn[7:0] == `QRY_SIG_FIRST_OFF
        |=> dqOut_reg == 16'h0051 && !dqDriveN_reg)
        else $error("query signature byte wrong");

    a_query_upper: assert property (@(posedge mclk) disable iff (reset)
        state_reg == flash_seq_pkg::S_QUERY && rdActive
        |=> dqOut_reg[15:8] == 8'h00)
        else $error("query upper byte not zero");

    a_status_first: assert property (@(posedge mclk) disable iff (reset)
        befpState && rdActive && atFirst
        |=> dqOut_reg == {8'h00, $past(srView)})
        else $error("status not shown at first word");

endmodule // flash_buffered_program_and_query

// File: bench/flash_host_model.sv
`timescale 1ns/1ps

module flash_host_model (
    input  wire logic        mclk,
    input  wire logic [15:0] dqOut,
    input  wire logic        dqDriveN,
    output logic      [23:0] addrIn,
    output logic      [15:0] dqIn,
    output logic             chipEnN,
    output logic             writeEnN,
    output logic             outEnN
);
    initial begin
        addrIn   = 24'h000000;
        dqIn     = 16'h0000;
        chipEnN  = 1'b1;
        writeEnN = 1'b1;
        outEnN   = 1'b1;
    end

    // one write, taken on the rising edge of writeEnN with chip enabled
    task automatic wr(input logic [23:0] a, input logic [15:0] d);
        @(negedge mclk);
        addrIn   = a;
        dqIn     = d;
        chipEnN  = 1'b0;
        writeEnN = 1'b0;
        @(negedge mclk);
        writeEnN = 1'b1;
        @(negedge mclk);
        chipEnN = 1'b1;
        dqIn    = ~d;
    endtask

    // one read, held until the registered answer has settled
    task automatic rd(input logic [23:0] a, output logic [15:0] d,
                      output logic drvN);
        @(negedge mclk);
        addrIn  = a;
        chipEnN = 1'b0;
        outEnN  = 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        d       = dqOut;
        drvN    = dqDriveN;
        chipEnN = 1'b1;
        outEnN  = 1'b1;
    endtask
endmodule // flash_host_model

// File: bench/flash_buffered_program_and_query_bench.sv
`timescale 1ns/1ps

module flash_buffered_program_and_query_bench;
    localparam logic [23:0] BLK_A = 24'h030040;
    localparam logic [23:0] OTHER = 24'h050000;
    localparam logic [23:0] BLK_B = 24'h040020;
    logic [23:0] curBlk;
    logic        mclk;
    logic        reset;
    logic        hv;
    logic        locked;
    logic        dqDriveN;
    logic        arrayWe;
    logic        chipEnN;
    logic        writeEnN;
    logic        outEnN;
    logic        drv;
    logic [23:0] addrIn;
    logic [23:0] arrayAddr;
    logic [23:0] expAddr;
    logic [15:0] dqIn;
    logic [15:0] dqOut;
    logic [15:0] arrayData;
    logic [15:0] rdv;
    logic [15:0] expQ[$];
    int          n_fail;
    int          checked;
    int          nWe;
    wire  [15:0] arrayRdData = addrIn[15:0] ^ 16'h5a5a;

    flash_buffered_program_and_query u_flash_buffered_program_and_query (
        .mclk(mclk), .reset(reset), .addrIn(addrIn), .dqIn(dqIn),
        .dqOut(dqOut), .dqDriveN(dqDriveN), .chipEnN(chipEnN),
        .writeEnN(writeEnN), .outEnN(outEnN), .highProgramVoltage(hv),
        .blockLocked(locked), .arrayRdData(arrayRdData),
        .arrayWe(arrayWe), .arrayAddr(arrayAddr), .arrayData(arrayData));

    flash_host_model u_flash_host_model (
        .mclk(mclk), .dqOut(dqOut), .dqDriveN(dqDriveN), .addrIn(addrIn),
        .dqIn(dqIn), .chipEnN(chipEnN), .writeEnN(writeEnN),
        .outEnN(outEnN));

    task automatic check(input string what, input logic [23:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // reads status at the first word until bit b equals v, bounded
    task automatic poll(input int b, input logic v);
        for (int k = 0; k < 200; k++) begin
            u_flash_host_model.rd(curBlk, rdv, drv);
            if (rdv[b] === v) break;
        end
        check("status poll", rdv[b], v);
    endtask

    // array write monitor: order, address and data of programmed words
    always @(posedge mclk) begin
        if (arrayWe === 1'b1) begin
            check("array addr", arrayAddr, expAddr);
            check("array data", arrayData, expQ.pop_front());
            expAddr = expAddr + 24'h000001;
            nWe++;
        end
    end

    task automatic t_query;
        logic [7:0] tbl [11] = '{8'h51, 8'h52, 8'h59, 8'h07, 8'h00, 8'h0a,
                                 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
        u_flash_host_model.wr(24'h000000, 16'h0098);
        for (int i = 0; i < 11; i++) begin
            u_flash_host_model.rd(24'h000010 + 24'(i), rdv, drv);
            check("qhigh", rdv[15:8], 8'h00);
            check("qbyte", rdv[7:0], tbl[i]);
            check("qdrive", drv, 1'b0);
        end
        u_flash_host_model.wr(24'h000000, 16'h00ff);
        u_flash_host_model.rd(24'h000010, rdv, drv);
        check("array read", rdv, 16'h0010 ^ 16'h5a5a);
    endtask

    task automatic t_setup_err(input logic h, input logic l);
        @(negedge mclk);
        hv     = h;
        locked = l;
        u_flash_host_model.wr(BLK_A, 16'h0080);
        u_flash_host_model.wr(BLK_A, 16'h0080);
        poll(7, 1'b1);
        check("vpp error", rdv[3], !h);
        check("lock error", rdv[1], l);
        u_flash_host_model.wr(BLK_A, 16'h0050);
        @(negedge mclk);
        hv     = 1'b1;
        locked = 1'b0;
    endtask

    task automatic t_buffered_factory_program(input logic [23:0] blk);
        curBlk  = blk;
        nWe     = 0;
        expAddr = blk;
        u_flash_host_model.wr(blk, 16'h0080);
        u_flash_host_model.wr(blk, 16'h0080);
        poll(7, 1'b0);
        check("data ready", rdv[0], 1'b0);
        for (int f = 0; f < 2; f++) begin
            for (int i = 0; i < 32; i++) begin
                expQ.push_back(16'h0a00 + 16'(f * 32 + i));
                u_flash_host_model.wr(blk, 16'h0a00 + 16'(f * 32 + i));
            end
            u_flash_host_model.rd(blk, rdv, drv);
            check("busy after fill", rdv[0], 1'b1);
            u_flash_host_model.wr(blk, 16'hdead);
            u_flash_host_model.rd(blk + 24'h000001, rdv, drv);
            check("other word", rdv, (blk[15:0] + 16'h0001) ^ 16'h5a5a);
            poll(0, 1'b0);
        end
        check("words programmed", nWe, 64);
        u_flash_host_model.wr(OTHER, 16'hffff);
        u_flash_host_model.rd(blk, rdv, drv);
        check("exit pending", rdv[7], 1'b0);
        poll(7, 1'b1);
        check("no errors", {rdv[3], rdv[1]}, 2'b00);
        u_flash_host_model.wr(blk, 16'h00ff);
        u_flash_host_model.rd(blk, rdv, drv);
        check("array after exit", rdv, blk[15:0] ^ 16'h5a5a);
    endtask

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        end_sim();
    end

    initial begin
        n_fail  = 0;
        checked = 0;
        nWe     = 0;
        expAddr = 24'h000000;
        curBlk  = BLK_A;
        reset   = 1'b1;
        hv      = 1'b1;
        locked  = 1'b0;
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        reset = 1'b0;
        @(negedge mclk);
        t_query();
        t_setup_err(1'b0, 1'b0);
        t_setup_err(1'b1, 1'b1);
        t_buffered_factory_program(BLK_A);
        t_buffered_factory_program(BLK_B);
        end_sim();
    end
endmodule // flash_buffered_program_and_query_bench
